// ### src/rtc_cfg_regs.svh
// Register offsets, field positions, reset values and timing for the clock configuration slice
// Behaviour
// R1: Configuration register returns to defaults only on power-on reset, never on other resets.
// R2: Clock enable bit accepts writes only while the write-enable unlock bit is 1.
// R3: Half-second status is read-only; writing the minutes/seconds low byte clears it.
// R4: Half-second status reads 1 in second half of each second, 0 in first.
// R5: Two-bit pointer selects window pair: 00 min/sec, 01 weekday/hour, 10 month/day, 11 reserved.
`ifndef RTC_CFG_REGS_SVH
`define RTC_CFG_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CFG_OFFSET 4'h0
`define WINDOW_OFFSET 4'h4

// ----------------------------------------
// Configuration field positions
// ----------------------------------------
`define CFG_CLOCK_ENABLE_BIT 15
`define CFG_UNLOCK_BIT 13
`define CFG_SYNC_BIT 12
`define CFG_HALF_SECOND_BIT 11
`define CFG_OUTPUT_ENABLE_BIT 10
`define CFG_POINTER_HI 9
`define CFG_POINTER_LO 8
`define CFG_CAL_HI 7
`define CFG_CAL_LO 0

// ----------------------------------------
// Reset values and pointer codes
// ----------------------------------------
`define CAL_RESET 8'h00
`define POINTER_RESET 2'h0
`define POINTER_MIN_SEC 2'h0
`define POINTER_RESERVED 2'h3
`define VALUE_RESET 16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define SECOND_NS 1000000000
`define CLOCK_PERIOD_NS 8
`define SECOND_CYCLES (`SECOND_NS / `CLOCK_PERIOD_NS)

`endif

// ### src/rtc_cfg_pkg.sv
// Types shared by the clock configuration slice
package rtc_cfg_pkg;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'h1,
		BUS_ACK = 2'h2
	} bus_phase_type;
endpackage

// ### src/half_second_counter.sv
// One-second prescaler that produces the half-second status
`timescale 1ns/1ps
`include "rtc_cfg_regs.svh"

module half_second_counter #(
	parameter int unsigned CYCLES = `SECOND_CYCLES
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic run_i,
	input wire logic restart_i,
	output logic half_o
);
	localparam int unsigned W = $clog2(CYCLES);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);
	localparam logic [W-1:0] HALF = W'(CYCLES / 2);

	logic [W-1:0] count_q;
	logic [W-1:0] count_d;

	always_comb begin
		if (restart_i) begin
			count_d = '0;
		end else if (!run_i) begin
			count_d = count_q;
		end else if (count_q == LAST) begin
			count_d = '0;
		end else begin
			count_d = count_q + W'(1);
		end
	end

	// Flag is flopped from the next count so it tracks count_q exactly
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			count_q <= '0;
			half_o <= 1'b0;
		end else if (ce_i) begin
			count_q <= count_d;
			half_o <= (count_d >= HALF); // [R4]
		end
	end

	half_tracks_count_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		half_o == (count_q >= HALF)) else $error("half-second flag disagrees with count"); // [R4]
endmodule // half_second_counter

// ### src/rtc_cfg_status.sv
// Clock configuration register, value window and Avalon-MM slave
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "rtc_cfg_regs.svh"

module rtc_cfg_status #(
	parameter int unsigned SECOND_CYCLES = `SECOND_CYCLES
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic soft_resetn_i,
	input wire logic ce_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic clock_enable_o,
	output logic clock_output_enable_o,
	output logic half_second_o,
	output logic [1:0] value_window_pointer_o
);
	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	rtc_cfg_pkg::bus_phase_type phase_q;
	logic request;
	logic done;
	logic cfg_hit;
	logic window_hit;
	logic cfg_wr;
	logic window_wr;
	logic minutes_seconds_value_low_wr;
	logic [15:0] cfg_view;
	logic [15:0] window_view;

	assign request = avs_read_i | avs_write_i;
	// Frozen clock enable holds the answer back, else a write would be reported done yet dropped
	assign done = request && ce_i && (phase_q == rtc_cfg_pkg::BUS_ACK);
	assign avs_waitrequest_o = request && !done;
	assign cfg_hit = (avs_address_i == `CFG_OFFSET);
	assign window_hit = (avs_address_i == `WINDOW_OFFSET);
	assign cfg_wr = done && avs_write_i && cfg_hit;
	assign window_wr = done && avs_write_i && window_hit && (value_window_pointer_o != `POINTER_RESERVED);
	assign minutes_seconds_value_low_wr = window_wr && (value_window_pointer_o == `POINTER_MIN_SEC) && avs_byteenable_i[0];

	// Other reset sources only idle the handshake; configuration keeps its contents
	always_ff @(posedge clock_i) begin
		if (!resetn_i || !soft_resetn_i) begin
			phase_q <= rtc_cfg_pkg::BUS_IDLE;
		end else if (ce_i) begin
			unique case (phase_q)
				rtc_cfg_pkg::BUS_IDLE: begin
					if (request) begin
						phase_q <= rtc_cfg_pkg::BUS_ACK;
					end
				end
				rtc_cfg_pkg::BUS_ACK: begin
					phase_q <= rtc_cfg_pkg::BUS_IDLE;
				end
				default: begin
					phase_q <= rtc_cfg_pkg::BUS_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Configuration register
	// ----------------------------------------
	logic unlock_q;
	logic [7:0] cal_q;

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin // [R1]
			clock_enable_o <= 1'b0;
			unlock_q <= 1'b0;
			clock_output_enable_o <= 1'b0;
			value_window_pointer_o <= `POINTER_RESET;
		end else if (ce_i && cfg_wr && avs_byteenable_i[1]) begin
			// Lock is judged on the old unlock value, so one write cannot unlock and flip together
			if (unlock_q) begin
				clock_enable_o <= avs_writedata_i[`CFG_CLOCK_ENABLE_BIT]; // [R2]
			end
			unlock_q <= avs_writedata_i[`CFG_UNLOCK_BIT];
			clock_output_enable_o <= avs_writedata_i[`CFG_OUTPUT_ENABLE_BIT];
			value_window_pointer_o <= avs_writedata_i[`CFG_POINTER_HI:`CFG_POINTER_LO]; // [R5]
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin // [R1]
			cal_q <= `CAL_RESET;
		end else if (ce_i && cfg_wr && avs_byteenable_i[0]) begin
			cal_q <= avs_writedata_i[`CFG_CAL_HI:`CFG_CAL_LO];
		end
	end

	// ----------------------------------------
	// Value window storage
	// ----------------------------------------
	logic [15:0] value_q [3];

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < 3; i++) begin
				value_q[i] <= `VALUE_RESET;
			end
		end else if (ce_i && window_wr) begin // [R5]
			for (int b = 0; b < 2; b++) begin
				if (avs_byteenable_i[b]) begin
					value_q[value_window_pointer_o][b*8 +: 8] <= avs_writedata_i[b*8 +: 8];
				end
			end
		end
	end

	// ----------------------------------------
	// Half-second status
	// ----------------------------------------
	half_second_counter #(
		.CYCLES(SECOND_CYCLES)
	) i_half_second_counter (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.run_i(clock_enable_o),
		.restart_i(minutes_seconds_value_low_wr), // [R3]
		.half_o(half_second_o)
	);

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb begin
		cfg_view = 16'h0000;
		cfg_view[`CFG_CLOCK_ENABLE_BIT] = clock_enable_o;
		cfg_view[`CFG_UNLOCK_BIT] = unlock_q;
		cfg_view[`CFG_HALF_SECOND_BIT] = half_second_o; // [R3]
		cfg_view[`CFG_OUTPUT_ENABLE_BIT] = clock_output_enable_o;
		cfg_view[`CFG_POINTER_HI:`CFG_POINTER_LO] = value_window_pointer_o;
		cfg_view[`CFG_CAL_HI:`CFG_CAL_LO] = cal_q;
	end

	// Reserved pointer code shows zeros and swallows writes
	assign window_view = (value_window_pointer_o == `POINTER_RESERVED) ? 16'h0000 :
		value_q[value_window_pointer_o]; // [R5]

	// Loaded in the wait cycle so data stand at the edge the master samples
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (ce_i && avs_read_i && phase_q == rtc_cfg_pkg::BUS_IDLE) begin
			if (cfg_hit) begin
				avs_readdata_o <= {16'h0000, cfg_view};
			end else if (window_hit) begin
				avs_readdata_o <= {16'h0000, window_view};
			end else begin
				avs_readdata_o <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	soft_reset_keeps_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		!soft_resetn_i |=> $stable(clock_enable_o) && $stable(cal_q) && $stable(value_window_pointer_o))
		else $error("configuration changed under a non power-on reset"); // [R1]

	enable_lock_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		cfg_wr && !unlock_q |=> $stable(clock_enable_o)) else $error("clock enable written while locked"); // [R2]

	enable_unlock_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		ce_i && cfg_wr && unlock_q && avs_byteenable_i[1]
		|=> clock_enable_o == $past(avs_writedata_i[`CFG_CLOCK_ENABLE_BIT]))
		else $error("unlocked clock enable write lost"); // [R2]

	half_clear_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		ce_i && minutes_seconds_value_low_wr |=> !half_second_o) else $error("half-second not cleared by seconds write"); // [R3]

	half_read_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		done && avs_read_i && cfg_hit |-> avs_readdata_o[`CFG_HALF_SECOND_BIT] == $past(half_second_o))
		else $error("half-second read value wrong"); // [R4]

	reserved_window_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
		done && avs_read_i && window_hit && value_window_pointer_o == `POINTER_RESERVED
		&& $stable(value_window_pointer_o) |-> avs_readdata_o == 32'h0000_0000)
		else $error("reserved window pointer read nonzero"); // [R5]

	bus_answer_a: assert property (@(posedge clock_i) disable iff (!resetn_i || !soft_resetn_i)
		ce_i && request && phase_q == rtc_cfg_pkg::BUS_IDLE && !$past(request) |=> ce_i |-> !avs_waitrequest_o)
		else $error("slave answer later than one wait cycle");
endmodule // rtc_cfg_status

// ### test/rtc_config_status_bits_bench.sv
// Self-checking bench for the clock configuration slice
`timescale 1ns/1ps
`include "rtc_cfg_regs.svh"
module rtc_config_status_bits_bench;
localparam int unsigned SEC = 16;
logic clock_i = 1'b0;
logic resetn_i = 1'b0;
logic soft_resetn_i = 1'b1;
logic ce_i = 1'b1;
logic [3:0] avs_address_i = 4'h0;
logic avs_read_i = 1'b0;
logic avs_write_i = 1'b0;
logic [31:0] avs_writedata_i = 32'h0;
logic [3:0] avs_byteenable_i = 4'h3;
logic [31:0] avs_readdata_o;
logic avs_waitrequest_o;
logic clock_enable_o;
logic clock_output_enable_o;
logic half_second_o;
logic [1:0] value_window_pointer_o;
int err_count = 0;
int total_checks = 0;
always #4 clock_i = ~clock_i;
rtc_cfg_status #(.SECOND_CYCLES(SEC)) i_rtc_cfg_status (.clock_i(clock_i), .resetn_i(resetn_i),
	.soft_resetn_i(soft_resetn_i), .ce_i(ce_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .clock_enable_o(clock_enable_o),
	.clock_output_enable_o(clock_output_enable_o), .half_second_o(half_second_o),
	.value_window_pointer_o(value_window_pointer_o));
// ----------------------------------------
// Bus and compare helpers
// ----------------------------------------
task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
	total_checks++;
	if (got !== exp) begin
		err_count++;
		$display("FAIL %s expected %h seen %h", name, exp, got);
	end
endtask
// Sampled at the rising edge itself, before any update of that edge lands
task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
	@(posedge clock_i);
	avs_address_i <= a;
	avs_writedata_i <= d;
	avs_write_i <= wr;
	avs_read_i <= !wr;
	do begin
		@(posedge clock_i);
	end while (avs_waitrequest_o !== 1'b0);
	rd = avs_readdata_o;
	avs_write_i <= 1'b0;
	avs_read_i <= 1'b0;
endtask
task automatic wr(input logic [3:0] a, input logic [31:0] d);
	logic [31:0] x;
	bus(1'b1, a, d, x);
	// Registered outputs settle only after the accepting edge
	@(negedge clock_i);
endtask
// Half-second bit is masked where the running counter makes it unpredictable
task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
	logic [31:0] x;
	bus(1'b0, a, 32'h0, x);
	check(name, exp & m, x & m);
endtask
task automatic give_verdict();
	$display("checks %0d mismatches %0d", total_checks, err_count);
	if (err_count == 0 && total_checks > 0) $display("Regression OK");
	else $display("Regression broken");
	$finish;
endtask
// ----------------------------------------
// Scenarios
// ----------------------------------------
task automatic t_lock();
	rd_chk("cfg_reset", `CFG_OFFSET, 32'h0, 32'hFFFFFFFF);
	wr(`CFG_OFFSET, 32'h8000);
	check("enable_locked", 32'h0, {31'h0, clock_enable_o});
	wr(`CFG_OFFSET, 32'hA000);
	check("enable_old_unlock", 32'h0, {31'h0, clock_enable_o});
	wr(`CFG_OFFSET, 32'hA400);
	check("enable_unlocked", 32'h1, {31'h0, clock_enable_o});
	check("output_enable", 32'h1, {31'h0, clock_output_enable_o});
	$display("test lock done");
endtask
task automatic t_soft();
	@(posedge clock_i);
	soft_resetn_i <= 1'b0;
	repeat (3) @(posedge clock_i);
	soft_resetn_i <= 1'b1;
	rd_chk("cfg_after_soft", `CFG_OFFSET, 32'hA400, 32'hFFFFF7FF);
	$display("test soft reset done");
endtask
task automatic t_half();
	int ones;
	// Clear only shows if the flag was set just before the write
	@(negedge clock_i);
	while (half_second_o !== 1'b0) @(negedge clock_i);
	while (half_second_o !== 1'b1) @(negedge clock_i);
	wr(`WINDOW_OFFSET, 32'h1234);
	check("half_cleared", 32'h0, {31'h0, half_second_o});
	wr(`CFG_OFFSET, 32'hAC00);
	check("half_read_only", 32'h0, {31'h0, half_second_o});
	rd_chk("half_read_bit", `CFG_OFFSET, 32'h0, 32'h00000800);
	ones = 0;
	repeat (SEC) begin
		@(negedge clock_i);
		if (half_second_o === 1'b1) ones++;
	end
	check("half_duty", SEC / 2, ones);
	wr(`WINDOW_OFFSET, 32'h0012);
	ones = 0;
	for (int i = 0; i < SEC; i++) begin
		if (half_second_o !== ((i >= SEC / 2) ? 1'b1 : 1'b0)) ones++;
		@(negedge clock_i);
	end
	check("half_phase", 32'h0, ones);
	$display("test half second done");
endtask
task automatic t_freeze();
	int misses;
	@(negedge clock_i);
	while (half_second_o !== 1'b0) @(negedge clock_i);
	while (half_second_o !== 1'b1) @(negedge clock_i);
	@(posedge clock_i);
	ce_i <= 1'b0;
	avs_address_i <= `CFG_OFFSET;
	avs_writedata_i <= 32'h2000;
	avs_write_i <= 1'b1;
	misses = 0;
	repeat (SEC) begin
		@(posedge clock_i);
		if (avs_waitrequest_o !== 1'b1) misses++;
		if (half_second_o !== 1'b1) misses++;
	end
	check("frozen", 32'h0, misses);
	ce_i <= 1'b1;
	do begin
		@(posedge clock_i);
	end while (avs_waitrequest_o !== 1'b0);
	avs_write_i <= 1'b0;
	@(negedge clock_i);
	check("thaw_write", 32'h0, {31'h0, clock_enable_o});
	$display("test clock enable freeze done");
endtask
task automatic t_window();
	for (int p = 0; p < 4; p++) begin
		wr(`CFG_OFFSET, 32'hA400 | (p << 8));
		check("pointer", p, {30'h0, value_window_pointer_o});
		wr(`WINDOW_OFFSET, 32'h1100 + p);
		rd_chk("window", `WINDOW_OFFSET, (p == 3) ? 32'h0 : 32'h1100 + p, 32'hFFFFFFFF);
	end
	for (int p = 0; p < 3; p++) begin
		wr(`CFG_OFFSET, 32'hA400 | (p << 8));
		rd_chk("window_kept", `WINDOW_OFFSET, 32'h1100 + p, 32'hFFFFFFFF);
	end
	wr(4'h8, 32'hFFFF);
	rd_chk("unmapped", 4'h8, 32'h0, 32'hFFFFFFFF);
	$display("test window done");
endtask
task automatic t_lanes();
	@(posedge clock_i);
	avs_byteenable_i <= 4'h1;
	wr(`CFG_OFFSET, 32'h005A);
	rd_chk("cal_lane", `CFG_OFFSET, 32'hA65A, 32'hFFFFF7FF);
	@(posedge clock_i);
	avs_byteenable_i <= 4'h2;
	wr(`CFG_OFFSET, 32'h0000);
	rd_chk("upper_lane", `CFG_OFFSET, 32'h005A, 32'hFFFFF7FF);
	wr(`CFG_OFFSET, 32'h8000);
	check("enable_relocked", 32'h0, {31'h0, clock_enable_o});
	wr(`WINDOW_OFFSET, 32'hBBCC);
	rd_chk("window_lane", `WINDOW_OFFSET, 32'hBB00, 32'hFFFFFFFF);
	@(posedge clock_i);
	avs_byteenable_i <= 4'h3;
	$display("test byte lanes done");
endtask
task automatic t_por();
	@(posedge clock_i);
	resetn_i <= 1'b0;
	repeat (5) @(posedge clock_i);
	resetn_i <= 1'b1;
	rd_chk("cfg_after_por", `CFG_OFFSET, 32'h0, 32'hFFFFFFFF);
	rd_chk("window_after_por", `WINDOW_OFFSET, 32'h0, 32'hFFFFFFFF);
	$display("test power-on reset done");
endtask
initial begin
	repeat (5) @(posedge clock_i);
	resetn_i <= 1'b1;
	t_lock();
	t_soft();
	t_half();
	t_freeze();
	t_window();
	t_lanes();
	t_por();
	give_verdict();
end
// Whole run needs well under a thousand cycles
initial begin
	repeat (5000) @(posedge clock_i);
	err_count++;
	give_verdict();
end
endmodule // rtc_config_status_bits_bench
